// ---- pkg/pag_defines.svh ----
// Purpose: Offsets, field positions, widths and codes of the PWM action generator.
// Assumes: Included by its bare name.
// Notes: Byte addresses on a 32-bit classic Wishbone slave.
`ifndef PAG_DEFINES_SVH
`define PAG_DEFINES_SVH
`define PAG_CNT_W 16
`define PAG_ADR_W 5
`define PAG_OFF_CMPA 5'h00
`define PAG_OFF_CMPB 5'h04
`define PAG_OFF_ACTA 5'h08
`define PAG_OFF_ACTB 5'h0C
`define PAG_OFF_UPD 5'h10
`define PAG_OFF_TRIG 5'h14
`define PAG_OFF_FORCE 5'h18
`define PAG_OFF_STAT 5'h1C
`define PAG_UPD_GFU 4
`define PAG_FRC_OSGO 0
`define PAG_FRC_OSACT 2
`define PAG_FRC_HEN 6
`define PAG_FRC_HLVL 8
`define PAG_FRC_HEVT 10
`define PAG_FRC_HSEL 11
`define PAG_ACT_HOLD 2'h0
`define PAG_ACT_CLR 2'h1
`define PAG_ACT_SET 2'h2
`define PAG_ACT_TOG 2'h3
`define PAG_UPD_IMM 2'h0
`define PAG_UPD_ZERO 2'h1
`define PAG_UPD_PER 2'h2
`define PAG_UPD_SYNC 2'h3
`define PAG_MODE_UP 2'h0
`define PAG_MODE_DOWN 2'h1
`define PAG_MODE_UD 2'h2
`define PAG_EV_UZ 0
`define PAG_EV_UP 1
`define PAG_EV_UA 2
`define PAG_EV_UB 3
`define PAG_EV_UT0 4
`define PAG_EV_UT1 5
`define PAG_EV_DZ 6
`define PAG_EV_DP 7
`define PAG_EV_DA 8
`define PAG_EV_DB 9
`define PAG_EV_DT0 10
`define PAG_EV_DT1 11
`endif

// ---- pkg/pag_pkg.sv ----
// Purpose: Types shared by the PWM action generator and its bench.
// Assumes: pag_defines.svh sets the widths.
// Notes: Structs carry the bus request and the timer reference.
`include "pag_defines.svh"
package pag_pkg;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [`PAG_ADR_W-1:0] adr;
		logic [31:0] dat;
	} pag_wb_req_t;
	typedef struct packed {
		logic [`PAG_CNT_W-1:0] cnt;
		logic [`PAG_CNT_W-1:0] period;
		logic dir_down;
		logic [1:0] mode;
		logic tick;
	} pag_timer_t;
endpackage

// ---- core/pag_top.sv ----
// Purpose: Action generator of one PWM operator, driving pwm_out_a and pwm_out_b.
// Assumes: Timer, trigger and sync inputs come from logic on clk_i; registers over classic Wishbone.
// Notes: Action codes are hold, clear, set, toggle; outputs feed the dead-time generator.
// Overview of operation
// - Up-down mode: period events only down, zero events only up.
// - Compare above period never raises compare events.
// - Up-count priority: force, period, t0, t1, B, A, zero.
// - Down-count priority: force, zero, t0, t1, B, A, period.
// - Up mode: period event precedes zero by one.
// - Down mode: zero event precedes period by one.
// - Events qualified by counting direction, except period and zero in up-down mode.
// - Actions: set high, clear low, toggle.
// - No-action leaves outputs; events still reported.
// - Separate action sets per output, any event.
// - Trigger sources chosen independently of trip setup.
// - Software force outranks events, ignores direction.
// - One-time force acts at once, events resume.
// - Held force holds until released; trigger selectable.
// - Forcing enabled per output separately.
// - Symmetric waveform: set on up-A, clear on down-A.
// - Compare events: count equals A or B, per direction.
// - Compares and actions shadowed, copied at update.
// - Update at zero, period, sync, immediately, or global.
`timescale 1ns/1ns
`include "pag_defines.svh"
module pag_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pag_pkg::pag_wb_req_t wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire pag_pkg::pag_timer_t timer_i,
	input wire logic [3:0] trig_src_i,
	input wire logic sync_evt_i,
	output logic pwm_out_a_o,
	output logic pwm_out_b_o,
	output logic [11:0] evt_pulse_o
);
	import pag_pkg::*;
	localparam int ORDER [12] = '{`PAG_EV_UZ, `PAG_EV_UA, `PAG_EV_UB, `PAG_EV_UT1, `PAG_EV_UT0, `PAG_EV_UP,
		`PAG_EV_DP, `PAG_EV_DA, `PAG_EV_DB, `PAG_EV_DT1, `PAG_EV_DT0, `PAG_EV_DZ};

	logic ack_reg;
	logic [31:0] dat_reg;
	logic [`PAG_CNT_W-1:0] sh_cmpa_reg, sh_cmpb_reg, cmpa_reg, cmpb_reg;
	logic [23:0] sh_act_reg [2];
	logic [23:0] act_reg [2];
	logic [1:0] upd_mode_reg;
	logic gfu_reg;
	logic [3:0] trig_cfg_reg;
	logic [14:0] force_reg;
	logic [1:0] os_go_reg;
	logic [1:0] hold_on_reg;
	logic [1:0] out_reg;
	logic [11:0] evt_reg;
	logic [11:0] ev;
	logic wr, rd_ok, upd_now, ud, period_m, zero_m, trig0, trig1, down;
	logic [`PAG_CNT_W-1:0] tmp_cnt;

	function automatic logic [31:0] pag_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// Walks from lowest to highest priority so the last hit wins.
	function automatic logic [1:0] pag_pick(input logic [23:0] act, input logic [11:0] evs);
		logic [1:0] r;
		r = `PAG_ACT_HOLD;
		for (int i = 0; i < 12; i++) begin
			if (evs[ORDER[i]]) begin
				r = act[2*ORDER[i] +: 2];
			end
		end
		return r;
	endfunction

	function automatic logic pag_apply(input logic [1:0] code, input logic cur);
		logic r;
		r = cur;
		unique case (code)
			`PAG_ACT_HOLD: r = cur;
			`PAG_ACT_CLR: r = 1'b0;
			`PAG_ACT_SET: r = 1'b1;
			`PAG_ACT_TOG: r = ~cur;
		endcase
		return r;
	endfunction

	assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_reg;
	assign tmp_cnt = timer_i.cnt;
	assign ud = (timer_i.mode == `PAG_MODE_UD);
	assign period_m = timer_i.tick & (tmp_cnt == timer_i.period);
	assign zero_m = timer_i.tick & (tmp_cnt == '0);
	// Trip inputs feed triggers straight; the fault handler's own setup is not consulted.
	assign trig0 = trig_src_i[trig_cfg_reg[1:0]];
	assign trig1 = trig_src_i[trig_cfg_reg[3:2]];
	assign down = timer_i.dir_down;

	always_comb begin
		ev = '0;
		// In up-down mode the timer turns at period and at zero, so those ends are forced to one direction.
		ev[`PAG_EV_UP] = period_m & ~down & ~ud;
		ev[`PAG_EV_DP] = period_m & (down | ud);
		ev[`PAG_EV_UZ] = zero_m & (~down | ud);
		ev[`PAG_EV_DZ] = zero_m & down & ~ud;
		ev[`PAG_EV_UA] = timer_i.tick & ~down & (tmp_cnt == cmpa_reg) & (cmpa_reg <= timer_i.period);
		ev[`PAG_EV_UB] = timer_i.tick & ~down & (tmp_cnt == cmpb_reg) & (cmpb_reg <= timer_i.period);
		ev[`PAG_EV_DA] = timer_i.tick & down & (tmp_cnt == cmpa_reg) & (cmpa_reg <= timer_i.period);
		ev[`PAG_EV_DB] = timer_i.tick & down & (tmp_cnt == cmpb_reg) & (cmpb_reg <= timer_i.period);
		ev[`PAG_EV_UT0] = trig0 & ~down;
		ev[`PAG_EV_UT1] = trig1 & ~down;
		ev[`PAG_EV_DT0] = trig0 & down;
		ev[`PAG_EV_DT1] = trig1 & down;
	end

	always_comb begin
		unique case (upd_mode_reg)
			`PAG_UPD_IMM: upd_now = 1'b1;
			`PAG_UPD_ZERO: upd_now = zero_m;
			`PAG_UPD_PER: upd_now = period_m;
			`PAG_UPD_SYNC: upd_now = sync_evt_i;
		endcase
		upd_now = upd_now | gfu_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		unique case (wb_req_i.adr)
			`PAG_OFF_CMPA, `PAG_OFF_CMPB, `PAG_OFF_ACTA, `PAG_OFF_ACTB, `PAG_OFF_UPD, `PAG_OFF_TRIG,
			`PAG_OFF_FORCE, `PAG_OFF_STAT: rd_ok = 1'b1;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= 32'h0;
		end else if (wb_req_i.cyc & wb_req_i.stb & ~ack_reg) begin
			dat_reg <= 32'h0;
			if (rd_ok) begin
				unique case (wb_req_i.adr)
					`PAG_OFF_CMPA: dat_reg <= 32'(sh_cmpa_reg);
					`PAG_OFF_CMPB: dat_reg <= 32'(sh_cmpb_reg);
					`PAG_OFF_ACTA: dat_reg <= 32'(sh_act_reg[0]);
					`PAG_OFF_ACTB: dat_reg <= 32'(sh_act_reg[1]);
					`PAG_OFF_UPD: dat_reg <= 32'(upd_mode_reg);
					`PAG_OFF_TRIG: dat_reg <= 32'(trig_cfg_reg);
					`PAG_OFF_FORCE: dat_reg <= 32'(force_reg);
					`PAG_OFF_STAT: dat_reg <= 32'({hold_on_reg, down, out_reg});
					default: dat_reg <= 32'h0;
				endcase
			end
		end
	end

	// Software sees only the shadow copies; the active ones move at the chosen update moment.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sh_cmpa_reg <= '0;
			sh_cmpb_reg <= '0;
			sh_act_reg[0] <= 24'h0;
			sh_act_reg[1] <= 24'h0;
		end else if (wr) begin
			unique case (wb_req_i.adr)
				`PAG_OFF_CMPA: sh_cmpa_reg <= `PAG_CNT_W'(pag_merge(32'(sh_cmpa_reg), wb_req_i.dat, wb_req_i.sel));
				`PAG_OFF_CMPB: sh_cmpb_reg <= `PAG_CNT_W'(pag_merge(32'(sh_cmpb_reg), wb_req_i.dat, wb_req_i.sel));
				`PAG_OFF_ACTA: sh_act_reg[0] <= 24'(pag_merge(32'(sh_act_reg[0]), wb_req_i.dat, wb_req_i.sel));
				`PAG_OFF_ACTB: sh_act_reg[1] <= 24'(pag_merge(32'(sh_act_reg[1]), wb_req_i.dat, wb_req_i.sel));
				default: sh_cmpa_reg <= sh_cmpa_reg;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmpa_reg <= '0;
			cmpb_reg <= '0;
			act_reg[0] <= 24'h0;
			act_reg[1] <= 24'h0;
		end else if (upd_now) begin
			cmpa_reg <= sh_cmpa_reg;
			cmpb_reg <= sh_cmpb_reg;
			act_reg[0] <= sh_act_reg[0];
			act_reg[1] <= sh_act_reg[1];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upd_mode_reg <= `PAG_UPD_IMM;
			gfu_reg <= 1'b0;
			trig_cfg_reg <= 4'h0;
		end else begin
			gfu_reg <= wr & (wb_req_i.adr == `PAG_OFF_UPD) & wb_req_i.sel[0] & wb_req_i.dat[`PAG_UPD_GFU];
			if (wr & (wb_req_i.adr == `PAG_OFF_UPD) & wb_req_i.sel[0]) begin
				upd_mode_reg <= wb_req_i.dat[1:0];
			end
			if (wr & (wb_req_i.adr == `PAG_OFF_TRIG) & wb_req_i.sel[0]) begin
				trig_cfg_reg <= wb_req_i.dat[3:0];
			end
		end
	end

	// The one-time go bits are not stored; writing them only fires a single pulse.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			force_reg <= 15'h0;
			os_go_reg <= 2'h0;
		end else begin
			os_go_reg <= 2'h0;
			if (wr & (wb_req_i.adr == `PAG_OFF_FORCE)) begin
				force_reg <= 15'(pag_merge(32'(force_reg), wb_req_i.dat, wb_req_i.sel)) & 15'h7FFC;
				if (wb_req_i.sel[0]) begin
					os_go_reg <= wb_req_i.dat[`PAG_FRC_OSGO +: 2];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_reg <= 12'h0;
		end else begin
			evt_reg <= ev;
		end
	end

	generate
		for (genvar k = 0; k < 2; k++) begin : g_out
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					hold_on_reg[k] <= 1'b0;
				end else if (!force_reg[`PAG_FRC_HEN + k]) begin
					hold_on_reg[k] <= 1'b0;
				end else if (!force_reg[`PAG_FRC_HEVT] || ev[force_reg[`PAG_FRC_HSEL +: 4]]) begin
					hold_on_reg[k] <= 1'b1;
				end
			end

			// Force is checked before any event and without looking at the direction.
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					out_reg[k] <= 1'b0;
				end else if (hold_on_reg[k]) begin
					out_reg[k] <= force_reg[`PAG_FRC_HLVL + k];
				end else if (os_go_reg[k]) begin
					out_reg[k] <= pag_apply(force_reg[`PAG_FRC_OSACT + 2*k +: 2], out_reg[k]);
				end else begin
					out_reg[k] <= pag_apply(pag_pick(act_reg[k], ev), out_reg[k]);
				end
			end
		end
	endgenerate

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign pwm_out_a_o = out_reg[0];
	assign pwm_out_b_o = out_reg[1];
	assign evt_pulse_o = evt_reg;

	ud_no_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ud |-> !ev[`PAG_EV_UP] && !ev[`PAG_EV_DZ]) else $error("Up-down mode raised a forbidden event.");
	cmp_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		((cmpa_reg > timer_i.period) |-> !ev[`PAG_EV_UA] && !ev[`PAG_EV_DA])
		and ((cmpb_reg > timer_i.period) |-> !ev[`PAG_EV_UB] && !ev[`PAG_EV_DB]))
		else $error("Compare out of range fired.");
	up_prio_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ev[`PAG_EV_UP] && ev[`PAG_EV_UA] && !hold_on_reg[0] && !os_go_reg[0] && act_reg[0][2*`PAG_EV_UP +: 2] == `PAG_ACT_SET
		|=> pwm_out_a_o) else $error("Up period did not win.");
	dn_prio_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ev[`PAG_EV_DZ] && ev[`PAG_EV_DA] && !hold_on_reg[0] && !os_go_reg[0]
		&& act_reg[0][2*`PAG_EV_DZ +: 2] == `PAG_ACT_CLR |=> !pwm_out_a_o) else $error("Down zero did not win.");
	up_apart_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ev[`PAG_EV_UP] |-> !ev[`PAG_EV_UZ]) else $error("Up period and up zero coincide.");
	dn_apart_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ev[`PAG_EV_DZ] |-> !ev[`PAG_EV_DP]) else $error("Down zero and down period coincide.");
	dir_qual_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ev[`PAG_EV_UA] || ev[`PAG_EV_UT0]) |-> !down) else $error("Up event while counting down.");
	hold_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
		hold_on_reg[1] |=> pwm_out_b_o == $past(force_reg[`PAG_FRC_HLVL + 1])) else $error("Held force lost on B.");
	os_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
		os_go_reg[0] && !hold_on_reg[0] && force_reg[`PAG_FRC_OSACT +: 2] == `PAG_ACT_CLR |=> !pwm_out_a_o)
		else $error("One-time force missed on A.");
	shadow_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!upd_now |=> cmpa_reg == $past(cmpa_reg)) else $error("Active compare moved without update.");
endmodule

// ---- tb/pag_timer_model.sv ----
// Purpose: Behavioural PWM timer feeding count, period, direction and tick to the action generator.
// Assumes: Runs on the generator clock; ticks every cycle, or every second cycle when slowed.
// Notes: The count returns to zero while stopped, so every run starts from a known phase.
`timescale 1ns/1ns
`include "pag_defines.svh"
module pag_timer_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic slow_i,
	input wire logic [1:0] mode_i,
	input wire logic [15:0] period_i,
	output pag_pkg::pag_timer_t timer_o
);
	import pag_pkg::*;
	logic [15:0] cnt_reg;
	logic ph_reg;
	logic dn_reg;
	logic tick;
	assign tick = run_i && (!slow_i || ph_reg);
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_reg <= 16'h0000;
			dn_reg <= 1'b0;
			ph_reg <= 1'b0;
		end else begin
			ph_reg <= !ph_reg;
			if (tick) begin
				case (mode_i)
					`PAG_MODE_UP: cnt_reg <= (cnt_reg == period_i) ? 16'h0000 : cnt_reg + 16'h0001;
					`PAG_MODE_DOWN: cnt_reg <= (cnt_reg == 16'h0000) ? period_i : cnt_reg - 16'h0001;
					default: begin
						// Direction turns as the peak or zero is reached, so it reads down at the peak.
						cnt_reg <= dn_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
						dn_reg <= dn_reg ? (cnt_reg != 16'h0001) : (cnt_reg + 16'h0001 == period_i);
					end
				endcase
			end
		end
	end
	assign timer_o = '{cnt: cnt_reg, period: period_i, mode: mode_i, tick: tick,
		dir_down: (mode_i == `PAG_MODE_DOWN) || (mode_i == `PAG_MODE_UD && dn_reg)};
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the PWM action generator.
// Assumes: pag_timer_model drives the timer link; registers are reached by classic Wishbone cycles.
// Notes: A cycle reference predicts events and output levels; triggers use sources 1 and 2.
`timescale 1ns/1ns
`include "pag_defines.svh"
module tb;
	import pag_pkg::*;
	localparam int LIMIT = 3000;
	logic clk_i = 1'b0, rst_i = 1'b1, run_en = 1'b0, slow = 1'b0, sync_evt_i = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [15:0] per = 16'h0005, ca = 16'h0000, cb = 16'h0000;
	logic [3:0] trig_src_i = 4'h0;
	pag_wb_req_t wb_req_i = '0;
	pag_timer_t timer_w;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, pwm_out_a_o, pwm_out_b_o, ea = 1'b0, eb = 1'b0, hold_b = 1'b0;
	logic [11:0] evt_pulse_o, ex_evt = 12'h000;
	logic [23:0] aa = 24'h000000, ab = 24'h000000;
	int miscompares = 0, total_checks = 0, cycles = 0;
	always #50 clk_i = ~clk_i;
	pag_timer_model u_pag_timer_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run_en), .slow_i(slow),
		.mode_i(mode), .period_i(per), .timer_o(timer_w));
	pag_top u_pag_top (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .timer_i(timer_w), .trig_src_i(trig_src_i), .sync_evt_i(sync_evt_i),
		.pwm_out_a_o(pwm_out_a_o), .pwm_out_b_o(pwm_out_b_o), .evt_pulse_o(evt_pulse_o));
	function automatic logic [11:0] evs(pag_timer_t t, logic [3:0] tr);
		logic z, p, a, b, d, u;
		d = t.dir_down;
		u = t.mode == `PAG_MODE_UD;
		z = t.tick && t.cnt == 16'h0000;
		p = t.tick && t.cnt == t.period;
		a = t.tick && t.cnt == ca && ca <= t.period;
		b = t.tick && t.cnt == cb && cb <= t.period;
		return {tr[2] && d, tr[1] && d, b && d, a && d, p && (u || d), z && !u && d,
			tr[2] && !d, tr[1] && !d, b && !d, a && !d, p && !u && !d, z && (u || !d)};
	endfunction
	function automatic logic app(logic cur, logic [11:0] e, logic [23:0] act);
		int ord[12] = '{1, 4, 5, 3, 2, 0, 6, 10, 11, 9, 8, 7};
		for (int i = 0; i < 12; i++) begin
			if (e[ord[i]]) begin
				case (act[2*ord[i] +: 2])
					`PAG_ACT_CLR: return 1'b0;
					`PAG_ACT_SET: return 1'b1;
					`PAG_ACT_TOG: return !cur;
					default: return cur;
				endcase
			end
		end
		return cur;
	endfunction
	always @(posedge clk_i) begin
		if (rst_i) begin
			ex_evt <= 12'h000;
			ea <= 1'b0;
			eb <= 1'b0;
		end else begin
			ex_evt <= evs(timer_w, trig_src_i);
			// A one-time force on A lands at the ack edge of its write and masks that cycle's events.
			if (wb_req_i.cyc && wb_req_i.we && wb_req_i.adr == `PAG_OFF_FORCE && wb_ack_o && wb_req_i.dat[0]) begin
				ea <= (wb_req_i.dat[3:2] == `PAG_ACT_CLR) ? 1'b0 : (wb_req_i.dat[3:2] == `PAG_ACT_SET) ? 1'b1 :
					(wb_req_i.dat[3:2] == `PAG_ACT_TOG) ? !ea : ea;
			end else begin
				ea <= app(ea, evs(timer_w, trig_src_i), aa);
			end
			if (!hold_b) begin
				eb <= app(eb, evs(timer_w, trig_src_i), ab);
			end
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	always @(negedge clk_i) begin
		if (!rst_i) begin
			chk("events", {20'h0, evt_pulse_o}, {20'h0, ex_evt});
			chk("out_a", {31'h0, pwm_out_a_o}, {31'h0, ea});
			chk("out_b", {31'h0, pwm_out_b_o}, {31'h0, eb});
		end
	end
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			miscompares++;
			$display("[FAIL] wb_ack expected 1 seen %b", wb_ack_o);
		end
		rd = wb_dat_o;
		wb_req_i <= '0;
		@(posedge clk_i);
	endtask
	// Triggers are pulsed on their own rhythm so that some land on timer events.
	task automatic run(input int n);
		run_en <= 1'b1;
		for (int i = 0; i < n; i++) begin
			trig_src_i <= (i % 7 == 3) ? 4'h2 : ((i % 9 == 4) ? 4'h4 : 4'h0);
			@(posedge clk_i);
		end
		trig_src_i <= 4'h0;
		run_en <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic cfg(input logic [1:0] m, input logic [15:0] p, a, b, input logic [23:0] xa, xb);
		mode <= m;
		per <= p;
		ca = a;
		cb = b;
		aa = xa;
		ab = xb;
		wb(1'b1, `PAG_OFF_UPD, 32'h0);
		wb(1'b1, `PAG_OFF_CMPA, {16'h0, a});
		wb(1'b1, `PAG_OFF_CMPB, {16'h0, b});
		wb(1'b1, `PAG_OFF_ACTA, {8'h0, xa});
		wb(1'b1, `PAG_OFF_ACTB, {8'h0, xb});
	endtask
	task automatic t_reset();
		wb(1'b0, `PAG_OFF_STAT, 32'h0);
		chk("status", rd, 32'h0);
		wb(1'b1, `PAG_OFF_STAT, 32'hFFFFFFFF);
		wb(1'b0, 5'h1E, 32'h0);
		chk("unmapped", rd, 32'h0);
		wb(1'b1, `PAG_OFF_TRIG, 32'h9);
		wb(1'b1, `PAG_OFF_CMPA, 32'hFFFF1234);
		wb(1'b0, `PAG_OFF_CMPA, 32'h0);
		chk("cmpa_shadow", rd, 32'h00001234);
	endtask
	task automatic t_up();
		cfg(`PAG_MODE_UP, 16'h5, 16'h5, 16'h7, 24'h000019, 24'h0002C3);
		run(40);
	endtask
	task automatic t_down();
		cfg(`PAG_MODE_DOWN, 16'h6, 16'h0, 16'h3, 24'h061000, 24'hC09000);
		slow <= 1'b1;
		run(60);
		slow <= 1'b0;
	endtask
	task automatic t_ud();
		cfg(`PAG_MODE_UD, 16'h6, 16'h2, 16'h4, 24'h010020, 24'h304002);
		run(50);
	endtask
	task automatic t_shadow();
		wb(1'b1, `PAG_OFF_UPD, 32'h3);
		wb(1'b1, `PAG_OFF_CMPA, 32'h5);
		run(30);
		sync_evt_i <= 1'b1;
		@(posedge clk_i);
		sync_evt_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		ca = 16'h0005;
		run(30);
		wb(1'b1, `PAG_OFF_CMPA, 32'h1);
		wb(1'b1, `PAG_OFF_UPD, 32'h13);
		ca = 16'h0001;
		run(30);
	endtask
	task automatic t_force();
		cfg(`PAG_MODE_UD, 16'h6, 16'h2, 16'h4, 24'h010020, 24'h304002);
		run(9);
		wb(1'b1, `PAG_OFF_FORCE, 32'h5);
		run(20);
		wb(1'b1, `PAG_OFF_FORCE, 32'h280);
		#1 eb = 1'b1;
		hold_b = 1'b1;
		@(posedge clk_i);
		wb(1'b0, `PAG_OFF_STAT, 32'h0);
		chk("status_hold", rd, {27'h0, 2'h2, 1'h0, 1'h1, ea});
		run(30);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_up();
		t_down();
		t_ud();
		t_shadow();
		t_force();
		tally_and_finish();
	end
endmodule
